//--- src/asf_defines.svh
// Register offsets, bit positions and reset values of the serial flag block.
// Assumes byte addresses on an 8-bit AXI4-Lite address bus.
`ifndef ASF_DEFINES_SVH
`define ASF_DEFINES_SVH
`define ASF_OFS_STAT1 8'h00
`define ASF_OFS_STAT2 8'h04
`define ASF_OFS_CTRL1 8'h08
`define ASF_OFS_CTRL2 8'h0C
`define ASF_OFS_CTRL3 8'h10
`define ASF_OFS_DATA 8'h14
`define ASF_OFS_CTRL4 8'h18
// Status one layout; bits 5..0 are the receive flag vector
`define ASF_S1_TXE 7
`define ASF_S1_TXC 6
`define ASF_RX_FULL 5
`define ASF_RX_IDLE 4
`define ASF_RX_OVR 3
`define ASF_RX_NOISE 2
`define ASF_RX_FRAME 1
`define ASF_RX_PAR 0
`define ASF_RX_NFLAGS 6
// Status two, write one to clear
`define ASF_S2_BRK 7
`define ASF_S2_EDGE 6
// Control one
`define ASF_C1_LOOP 7
`define ASF_C1_RECEIVER_SOURCE_SELECT 5
`define ASF_C1_NINE 4
// Control two
`define ASF_C2_TXEIE 7
`define ASF_C2_TXCIE 6
`define ASF_C2_RXFIE 5
`define ASF_C2_IDLIE 4
`define ASF_C2_RXEN 2
`define ASF_C2_SLEEP 1
`define ASF_C2_SLIDL 0
// Control three; bits 3..0 enable the four error flags
`define ASF_C3_RX9 7
`define ASF_C3_TX9 6
`define ASF_C3_DIR 5
`define ASF_C3_OVRIE 3
`define ASF_C3_PARIE 0
// Control four
`define ASF_C4_BRKIE 7
`define ASF_C4_EDGIE 6
`define ASF_RST_BYTE 8'h00
`define ASF_RST_WORD 32'h0000_0000
`define ASF_RST_RXD 9'h000
`endif

//--- src/asf_pkg.sv
// Types shared by the serial flag block.
// Assumes the defines header supplies all numeric constants except the response codes below.
package asf_pkg;
   // AXI4-Lite response codes
   typedef enum logic [1:0] {
      ASF_RESP_OKAY = 2'b00,
      ASF_RESP_SLVERR = 2'b10
   } asf_resp_t;
endpackage

//--- src/asf_flags.sv
// Status flags, interrupt grouping and extra modes of a serial transceiver.
// Assumes a transmit/receive core beside it that supplies character events.
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "asf_defines.svh"
module asf_flags
   import asf_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Transmit core
   input wire logic tx_shift_load,
   input wire logic tx_core_idle,
   input wire logic tx_serial_out,
   output logic tx_buf_valid,
   output logic [7:0] tx_shift_data,
   output logic tx_shift_ninth,
   // Receive core
   input wire logic rx_char_ready,
   input wire logic [8:0] rx_char_data,
   input wire logic rx_char_noise,
   input wire logic rx_char_framing,
   input wire logic rx_char_parity,
   input wire logic rx_idle_detect,
   input wire logic rx_break_detect,
   output logic rx_serial_in,
   // Mode outputs to the cores
   output logic nine_bit_mode,
   output logic rx_enable,
   // Pins
   input wire logic rxd_pin,
   input wire logic txd_pin_in,
   output logic txd_pin_out,
   output logic txd_pin_oe_n,
   output logic rxd_gpio_release,
   // Stop modes and wake
   input wire logic stop_light,
   input wire logic stop_deep,
   output logic wake_request,
   // Interrupt requests
   output logic irq_tx,
   output logic irq_rx,
   output logic irq_err
);

   // Address match, used by both bus channels
   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
      reg_hit = (addr[7:2] == ofs[7:2]);
   endfunction

   // Any mapped register
   function automatic logic reg_mapped(input logic [7:0] addr);
      reg_mapped = reg_hit(addr, `ASF_OFS_STAT1) | reg_hit(addr, `ASF_OFS_STAT2) |
         reg_hit(addr, `ASF_OFS_CTRL1) | reg_hit(addr, `ASF_OFS_CTRL2) |
         reg_hit(addr, `ASF_OFS_CTRL3) | reg_hit(addr, `ASF_OFS_DATA) |
         reg_hit(addr, `ASF_OFS_CTRL4);
   endfunction

   logic rst; // Reset or deep stop, both wipe the registers
   logic [7:0] ctrl_one_reg; // Loop, source and length select
   logic [7:0] ctrl_two_reg; // Enables and sleep
   logic [7:0] ctrl_three_reg; // Ninth bits, direction, error enables
   logic [7:0] ctrl_four_reg; // Break and edge enables
   logic [5:0] rx_stat_reg; // Full, idle, overrun, noise, framing, parity
   logic [5:0] armed_reg; // Flags seen set by a status read
   logic [5:0] rx_set; // Hardware set per flag
   logic [5:0] rx_clr; // Clear per flag
   logic idle_block_reg; // Idle may not set again yet
   logic rx_edge_flag_reg; // Receive input edge seen
   logic break_flag_reg; // Break seen
   logic [8:0] rx_data_reg; // Receive buffer with ninth bit
   logic [7:0] tx_buf_reg; // Transmit buffer
   logic tx_buf_valid_reg; // Transmit buffer holds a character
   logic tx_complete_reg; // Transmitter finished and idle
   logic rx_prev_reg; // Previous receive line level
   logic bvalid_reg;
   logic rvalid_reg;
   logic [1:0] bresp_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic wr_go, rd_go, wr_en;
   logic stat1_rd, data_rd, data_wr, stat2_wr;
   logic rx_on, sleeping, accept, ovr_set, edge_set;
   logic tx_empty;

   assign rst = !aresetn | stop_deep;

   // Bus handshakes: write address and data are taken together
   assign wr_go = s_axi_awvalid & s_axi_wvalid & !bvalid_reg;
   assign rd_go = s_axi_arvalid & !rvalid_reg;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = rd_go;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
   // Only the low byte lane carries register data
   assign wr_en = wr_go & s_axi_wstrb[0];
   assign stat1_rd = rd_go & reg_hit(s_axi_araddr, `ASF_OFS_STAT1);
   assign data_rd = rd_go & reg_hit(s_axi_araddr, `ASF_OFS_DATA);
   assign data_wr = wr_en & reg_hit(s_axi_awaddr, `ASF_OFS_DATA);
   assign stat2_wr = wr_en & reg_hit(s_axi_awaddr, `ASF_OFS_STAT2);

   // Write response channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= ASF_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= reg_mapped(s_axi_awaddr) ? ASF_RESP_OKAY : ASF_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // Read data mux; unmapped reads return zero
   always_comb begin
      rdata_next = `ASF_RST_WORD;
      // Word-aligned address, so items and selector share one width
      case ({s_axi_araddr[7:2], 2'b00})
         `ASF_OFS_STAT1: begin
            rdata_next[7:0] = {tx_empty, tx_complete_reg, rx_stat_reg};
         end
         `ASF_OFS_STAT2: begin
            rdata_next[`ASF_S2_BRK] = break_flag_reg;
            rdata_next[`ASF_S2_EDGE] = rx_edge_flag_reg;
         end
         `ASF_OFS_CTRL1: rdata_next[7:0] = ctrl_one_reg;
         `ASF_OFS_CTRL2: rdata_next[7:0] = ctrl_two_reg;
         `ASF_OFS_CTRL3: begin
            rdata_next[7:0] = ctrl_three_reg;
            rdata_next[`ASF_C3_RX9] = rx_data_reg[8];
         end
         `ASF_OFS_DATA: rdata_next[7:0] = rx_data_reg[7:0];
         `ASF_OFS_CTRL4: rdata_next[7:0] = ctrl_four_reg;
         default: rdata_next = `ASF_RST_WORD;
      endcase
   end

   // Read data channel; data held until rready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rresp_reg <= ASF_RESP_OKAY;
         rdata_reg <= `ASF_RST_WORD;
      end else if (rd_go) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= reg_mapped(s_axi_araddr) ? ASF_RESP_OKAY : ASF_RESP_SLVERR;
         rdata_reg <= rdata_next;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // Control registers; control three bit 7 is read-only
   always_ff @(posedge aclk) begin
      if (rst) begin
         ctrl_one_reg <= `ASF_RST_BYTE;
         ctrl_two_reg <= `ASF_RST_BYTE;
         ctrl_three_reg <= `ASF_RST_BYTE;
         ctrl_four_reg <= `ASF_RST_BYTE;
      end else if (wr_en) begin
         if (reg_hit(s_axi_awaddr, `ASF_OFS_CTRL1)) begin
            ctrl_one_reg <= s_axi_wdata[7:0];
         end
         if (reg_hit(s_axi_awaddr, `ASF_OFS_CTRL2)) begin
            ctrl_two_reg <= s_axi_wdata[7:0];
         end
         if (reg_hit(s_axi_awaddr, `ASF_OFS_CTRL3)) begin
            ctrl_three_reg <= {1'b0, s_axi_wdata[6:0]};
         end
         if (reg_hit(s_axi_awaddr, `ASF_OFS_CTRL4)) begin
            ctrl_four_reg <= s_axi_wdata[7:0];
         end
      end
   end

   assign nine_bit_mode = ctrl_one_reg[`ASF_C1_NINE];
   assign rx_enable = ctrl_two_reg[`ASF_C2_RXEN];
   assign rx_on = rx_enable;
   assign sleeping = ctrl_two_reg[`ASF_C2_SLEEP];

   // Receive events. A framing flag still set blocks the transfer.
   assign accept = rx_char_ready & rx_on & !sleeping & !rx_stat_reg[`ASF_RX_FULL] &
      !rx_stat_reg[`ASF_RX_FRAME];
   assign ovr_set = rx_char_ready & rx_on & !sleeping & rx_stat_reg[`ASF_RX_FULL];
   assign rx_set[`ASF_RX_FULL] = accept;
   assign rx_set[`ASF_RX_IDLE] = rx_idle_detect & rx_on & !idle_block_reg &
      (!sleeping | ctrl_two_reg[`ASF_C2_SLIDL]);
   assign rx_set[`ASF_RX_OVR] = ovr_set;
   assign rx_set[`ASF_RX_NOISE] = accept & rx_char_noise;
   assign rx_set[`ASF_RX_FRAME] = accept & rx_char_framing;
   assign rx_set[`ASF_RX_PAR] = accept & rx_char_parity;

   // Per-flag update: a status read arms, a data read clears; set wins
   genvar gi;
   generate
      for (gi = 0; gi < `ASF_RX_NFLAGS; gi++) begin : g_rx_flag
         assign rx_clr[gi] = data_rd & armed_reg[gi];
         always_ff @(posedge aclk) begin
            if (rst) begin
               rx_stat_reg[gi] <= 1'b0;
               armed_reg[gi] <= 1'b0;
            end else begin
               rx_stat_reg[gi] <= rx_set[gi] | (rx_stat_reg[gi] & !rx_clr[gi]);
               if (stat1_rd) begin
                  armed_reg[gi] <= rx_stat_reg[gi];
               end else if (data_rd) begin
                  armed_reg[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // Idle stays quiet after a clear until a new character arrives
   always_ff @(posedge aclk) begin
      if (rst) begin
         idle_block_reg <= 1'b0;
      end else if (accept) begin
         idle_block_reg <= 1'b0;
      end else if (rx_clr[`ASF_RX_IDLE]) begin
         idle_block_reg <= 1'b1;
      end
   end

   // Receive buffer; an overrun character is dropped here
   always_ff @(posedge aclk) begin
      if (rst) begin
         rx_data_reg <= `ASF_RST_RXD;
      end else if (accept) begin
         rx_data_reg <= rx_char_data;
      end
   end

   // Receive line source selection
   always_comb begin
      rx_serial_in = rxd_pin;
      if (ctrl_one_reg[`ASF_C1_LOOP]) begin
         if (!ctrl_one_reg[`ASF_C1_RECEIVER_SOURCE_SELECT]) begin
            rx_serial_in = tx_serial_out;
         end else if (ctrl_three_reg[`ASF_C3_DIR]) begin
            rx_serial_in = tx_serial_out;
         end else begin
            rx_serial_in = txd_pin_in;
         end
      end
   end

   // Pin drive; oe_n high releases the shared wire to the far end
   assign txd_pin_out = tx_serial_out;
   assign txd_pin_oe_n = ctrl_one_reg[`ASF_C1_LOOP] & ctrl_one_reg[`ASF_C1_RECEIVER_SOURCE_SELECT] &
      !ctrl_three_reg[`ASF_C3_DIR];
   assign rxd_gpio_release = ctrl_one_reg[`ASF_C1_LOOP];

   // Falling edge of the receive line; the idle line level is high
   assign edge_set = rx_on & rx_prev_reg & !rx_serial_in;
   always_ff @(posedge aclk) begin
      if (rst) begin
         rx_prev_reg <= 1'b1;
      end else begin
         rx_prev_reg <= rx_serial_in;
      end
   end

   // Write-one-to-clear flags; a new event beats a clear
   always_ff @(posedge aclk) begin
      if (rst) begin
         rx_edge_flag_reg <= 1'b0;
         break_flag_reg <= 1'b0;
      end else begin
         rx_edge_flag_reg <= edge_set |
            (rx_edge_flag_reg & !(stat2_wr & s_axi_wdata[`ASF_S2_EDGE]));
         break_flag_reg <= (rx_break_detect & rx_on & !sleeping) |
            (break_flag_reg & !(stat2_wr & s_axi_wdata[`ASF_S2_BRK]));
      end
   end

   // Wake only from light stop; deep stop holds all but the bus channels in reset
   assign wake_request = stop_light & rx_edge_flag_reg & ctrl_four_reg[`ASF_C4_EDGIE];

   // Transmit buffer; a write in the load cycle keeps the new character
   always_ff @(posedge aclk) begin
      if (rst) begin
         tx_buf_reg <= `ASF_RST_BYTE;
         tx_buf_valid_reg <= 1'b0;
      end else if (data_wr) begin
         tx_buf_reg <= s_axi_wdata[7:0];
         tx_buf_valid_reg <= 1'b1;
      end else if (tx_shift_load) begin
         tx_buf_valid_reg <= 1'b0;
      end
   end

   // Shifter copy; ninth bit taken at the same edge as the data
   always_ff @(posedge aclk) begin
      if (rst) begin
         tx_shift_data <= `ASF_RST_BYTE;
         tx_shift_ninth <= 1'b0;
      end else if (tx_shift_load & tx_buf_valid_reg) begin
         tx_shift_data <= tx_buf_reg;
         tx_shift_ninth <= ctrl_three_reg[`ASF_C3_TX9];
      end
   end

   // Complete only when nothing is queued and the core idles
   always_ff @(posedge aclk) begin
      if (rst) begin
         tx_complete_reg <= 1'b0;
      end else begin
         tx_complete_reg <= tx_core_idle & !tx_buf_valid_reg & !data_wr;
      end
   end

   assign tx_buf_valid = tx_buf_valid_reg;
   assign tx_empty = !tx_buf_valid_reg;

   // Interrupt grouping, each source masked on its own
   assign irq_tx = (tx_empty & ctrl_two_reg[`ASF_C2_TXEIE]) |
      (tx_complete_reg & ctrl_two_reg[`ASF_C2_TXCIE]);
   assign irq_rx = (rx_stat_reg[`ASF_RX_FULL] & ctrl_two_reg[`ASF_C2_RXFIE]) |
      (rx_stat_reg[`ASF_RX_IDLE] & ctrl_two_reg[`ASF_C2_IDLIE]) |
      (rx_edge_flag_reg & ctrl_four_reg[`ASF_C4_EDGIE]) |
      (break_flag_reg & ctrl_four_reg[`ASF_C4_BRKIE]);
   assign irq_err = |(rx_stat_reg[`ASF_RX_OVR:`ASF_RX_PAR] &
      ctrl_three_reg[`ASF_C3_OVRIE:`ASF_C3_PARIE]);

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (rst);

   property p_tx_irq;
      tx_empty && ctrl_two_reg[`ASF_C2_TXEIE] |-> irq_tx;
   endproperty
   a_tx_irq: assert property (p_tx_irq) else $error("empty not requesting");

   property p_full_clear;
      $fell(rx_stat_reg[`ASF_RX_FULL]) |-> $past(data_rd) && $past(armed_reg[`ASF_RX_FULL]);
   endproperty
   a_full_clear: assert property (p_full_clear) else $error("full cleared early");

   property p_noise_with_full;
      $rose(rx_stat_reg[`ASF_RX_NOISE]) |-> $rose(rx_stat_reg[`ASF_RX_FULL]);
   endproperty
   a_noise_with_full: assert property (p_noise_with_full) else $error("noise alone");

   property p_overrun;
      ovr_set |=> rx_stat_reg[`ASF_RX_OVR] && $stable(rx_data_reg);
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun wrong");

   property p_edge_clear;
      $fell(rx_edge_flag_reg) |-> $past(stat2_wr) && $past(s_axi_wdata[`ASF_S2_EDGE]);
   endproperty
   a_edge_clear: assert property (p_edge_clear) else $error("edge lost");

   property p_ninth_copy;
      tx_shift_load && tx_buf_valid_reg |=>
         tx_shift_ninth == $past(ctrl_three_reg[`ASF_C3_TX9]);
   endproperty
   a_ninth_copy: assert property (p_ninth_copy) else $error("ninth not copied");

   property p_wire_in;
      ctrl_one_reg[`ASF_C1_LOOP] && ctrl_one_reg[`ASF_C1_RECEIVER_SOURCE_SELECT] &&
         !ctrl_three_reg[`ASF_C3_DIR] |-> txd_pin_oe_n && rx_serial_in == txd_pin_in;
   endproperty
   a_wire_in: assert property (p_wire_in) else $error("pin direction wrong");

   property p_loop;
      ctrl_one_reg[`ASF_C1_LOOP] && !ctrl_one_reg[`ASF_C1_RECEIVER_SOURCE_SELECT] |->
         rx_serial_in == tx_serial_out && rxd_gpio_release && !txd_pin_oe_n;
   endproperty
   a_loop: assert property (p_loop) else $error("loop path wrong");

   property p_idle_block;
      idle_block_reg && !accept |=> !$rose(rx_stat_reg[`ASF_RX_IDLE]);
   endproperty
   a_idle_block: assert property (p_idle_block) else $error("idle rearmed");

   property p_sleep;
      sleeping |=> !$rose(rx_stat_reg[`ASF_RX_FULL]);
   endproperty
   a_sleep: assert property (p_sleep) else $error("full set in sleep");

   property p_err_irq;
      rx_stat_reg[`ASF_RX_OVR] && ctrl_three_reg[`ASF_C3_OVRIE] |-> irq_err;
   endproperty
   a_err_irq: assert property (p_err_irq) else $error("error not requesting");

endmodule

//--- verif/asf_core_model.sv
// Behavioural transmit and receive core standing beside the flag block.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps
module asf_core_model #(
   parameter int CHAR_CYCLES = 40
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Transmit side
   input wire logic tx_buf_valid,
   output logic tx_shift_load,
   output logic tx_core_idle,
   output logic tx_serial_out,
   // Receive side
   output logic rx_char_ready,
   output logic [8:0] rx_char_data,
   output logic rx_char_noise,
   output logic rx_char_framing,
   output logic rx_char_parity,
   output logic rx_idle_detect,
   output logic rx_break_detect
);
   int busy_reg; // Cycles left in the frame on the line
   // Idle only once the load pulse is gone, so complete cannot rise early
   assign tx_core_idle = (busy_reg == 0) && !tx_shift_load;
   // Take a waiting character when free; line toggles within a frame, idles high
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy_reg <= 0;
         tx_shift_load <= 1'b0;
         tx_serial_out <= 1'b1;
      end else begin
         tx_shift_load <= 1'b0;
         if (busy_reg == 0 && tx_buf_valid) begin
            tx_shift_load <= 1'b1;
            busy_reg <= CHAR_CYCLES;
         end else if (busy_reg > 0) begin
            busy_reg <= busy_reg - 1;
         end
         tx_serial_out <= (busy_reg > 1) ? ~tx_serial_out : 1'b1;
      end
   end
   // Quiet receive side at time zero
   initial begin
      rx_char_ready = 1'b0;
      rx_char_data = 9'h000;
      {rx_char_noise, rx_char_framing, rx_char_parity} = 3'b000;
      {rx_idle_detect, rx_break_detect} = 2'b00;
   end
   // One character for one cycle; data scrambled after, so nothing stale looks valid
   task automatic push(input logic [8:0] d, input logic nz, input logic fe, input logic pe);
      rx_char_ready <= 1'b1;
      rx_char_data <= d;
      {rx_char_noise, rx_char_framing, rx_char_parity} <= {nz, fe, pe};
      @(posedge aclk);
      rx_char_ready <= 1'b0;
      rx_char_data <= ~d;
      @(posedge aclk);
   endtask
   // Idle or break pulse of one cycle
   task automatic ev(input logic idl, input logic brk);
      {rx_idle_detect, rx_break_detect} <= {idl, brk};
      @(posedge aclk);
      {rx_idle_detect, rx_break_detect} <= 2'b00;
      @(posedge aclk);
   endtask
endmodule

//--- verif/tb_asf_flags.sv
// Self-checking bench for the serial flag block, driven over AXI4-Lite.
// Assumes the core model answers the transmit side and plays received characters.
`timescale 1ns/1ps
`include "asf_defines.svh"
module tb_asf_flags
   import asf_pkg::*;
;
   logic aclk, aresetn;
   logic [7:0] s_axi_awaddr, s_axi_araddr, tx_shift_data;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic tx_shift_load, tx_core_idle, tx_serial_out, tx_buf_valid, tx_shift_ninth;
   logic rx_char_ready, rx_char_noise, rx_char_framing, rx_char_parity;
   logic rx_idle_detect, rx_break_detect, rx_serial_in, nine_bit_mode, rx_enable;
   logic [8:0] rx_char_data;
   logic rxd_pin, txd_pin_in, txd_pin_out, txd_pin_oe_n, rxd_gpio_release;
   logic stop_light, stop_deep, wake_request, irq_tx, irq_rx, irq_err;
   logic ext_txd; // Far end on the shared transmit wire
   int mismatches, checked;
   // Wire level: our driver wins while enabled, else the far end
   assign txd_pin_in = txd_pin_oe_n ? ext_txd : txd_pin_out;
   asf_flags asf_flags_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_shift_load, .tx_core_idle,
      .tx_serial_out, .tx_buf_valid, .tx_shift_data, .tx_shift_ninth, .rx_char_ready,
      .rx_char_data, .rx_char_noise, .rx_char_framing, .rx_char_parity, .rx_idle_detect,
      .rx_break_detect, .rx_serial_in, .nine_bit_mode, .rx_enable, .rxd_pin, .txd_pin_in,
      .txd_pin_out, .txd_pin_oe_n, .rxd_gpio_release, .stop_light, .stop_deep,
      .wake_request, .irq_tx, .irq_rx, .irq_err);
   asf_core_model #(.CHAR_CYCLES(40)) asf_core_model_i (.aclk, .aresetn, .tx_buf_valid,
      .tx_shift_load, .tx_core_idle, .tx_serial_out, .rx_char_ready, .rx_char_data,
      .rx_char_noise, .rx_char_framing, .rx_char_parity, .rx_idle_detect, .rx_break_detect);
   // 25 MHz bus clock
   always #20 aclk = ~aclk;
   // Verdict and end of run
   task automatic finish_test;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // One compare for every kind of result
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("FAIL %s exp %h got %h", nm, e, g);
         mismatches++;
      end
   endtask
   function automatic logic sel(input int k);
      case (k)
         0: return s_axi_awready;
         1: return s_axi_bvalid;
         2: return s_axi_arready;
         3: return s_axi_rvalid;
         4: return !tx_core_idle;
         default: return tx_core_idle;
      endcase
   endfunction
   // Bounded wait, sampled at the falling edge so the value seen is the one taken
   task automatic wait_for(input int k);
      int n;
      n = 0;
      @(negedge aclk);
      while (sel(k) !== 1'b1) begin
         n++;
         if (n > 100) begin
            $display("FAIL wait %0d exp 1 got 0", k);
            mismatches++;
            finish_test;
         end
         @(negedge aclk);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask
   // Register write; address and data offered together
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
      input logic [1:0] er = ASF_RESP_OKAY);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      wait_for(0);
      @(posedge aclk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      wait_for(1);
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      step(1);
   endtask
   // Register read with expected byte and response
   task automatic rd(input logic [7:0] a, input logic [7:0] e,
      input logic [1:0] er = ASF_RESP_OKAY);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      wait_for(2);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      wait_for(3);
      chk($sformatf("rdata %h", a), {24'h00_0000, e}, s_axi_rdata);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      step(1);
   endtask
   // Sequence of scenarios
   initial begin
      {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'b00000;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
      {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3F;
      {rxd_pin, ext_txd, stop_light, stop_deep} = 4'b1100;
      mismatches = 0;
      checked = 0;
      step(6);
      aresetn <= 1'b1;
      step(2);
      rd(`ASF_OFS_STAT1, 8'hC0);
      chk("irq", 3'b000, {irq_tx, irq_rx, irq_err});
      // Nine-bit transmit, ninth bit written first and kept
      wr(`ASF_OFS_CTRL1, 8'h10);
      chk("nine", 1'b1, nine_bit_mode);
      wr(`ASF_OFS_CTRL2, 8'h84);
      chk("irq_tx", 1'b1, irq_tx);
      chk("rx_enable", 1'b1, rx_enable);
      wr(`ASF_OFS_CTRL3, 8'h40);
      wr(`ASF_OFS_DATA, 8'h5A);
      wait_for(4);
      step(1);
      chk("shift", 9'h15A, {tx_shift_ninth, tx_shift_data});
      rd(`ASF_OFS_STAT1, 8'h80);
      wr(`ASF_OFS_DATA, 8'hA3);
      chk("buf_valid", 1'b1, tx_buf_valid);
      rd(`ASF_OFS_STAT1, 8'h00);
      chk("irq_tx", 1'b0, irq_tx);
      wait_for(5);
      wait_for(4);
      step(1);
      chk("shift", 9'h1A3, {tx_shift_ninth, tx_shift_data});
      wait_for(5);
      // Back onto a rising edge before the next request goes out
      step(1);
      rd(`ASF_OFS_STAT1, 8'hC0);
      wr(`ASF_OFS_CTRL2, 8'h44);
      chk("irq_tx", 1'b1, irq_tx);
      // Receive with errors, then overrun
      wr(`ASF_OFS_CTRL2, 8'h34);
      wr(`ASF_OFS_CTRL3, 8'h0F);
      asf_core_model_i.push(9'h1A5, 1'b1, 1'b0, 1'b1);
      rd(`ASF_OFS_DATA, 8'hA5);
      rd(`ASF_OFS_STAT1, 8'hE5);
      chk("irq", 3'b011, {irq_tx, irq_rx, irq_err});
      rd(`ASF_OFS_CTRL3, 8'h8F);
      asf_core_model_i.push(9'h033, 1'b0, 1'b1, 1'b0);
      rd(`ASF_OFS_STAT1, 8'hED);
      rd(`ASF_OFS_DATA, 8'hA5);
      rd(`ASF_OFS_STAT1, 8'hC0);
      chk("irq_err", 1'b0, irq_err);
      // Sleep blocks receive flags, idle option excepted
      wr(`ASF_OFS_CTRL2, 8'h07);
      asf_core_model_i.push(9'h0AA, 1'b0, 1'b0, 1'b0);
      rd(`ASF_OFS_STAT1, 8'hC0);
      asf_core_model_i.ev(1'b1, 1'b0);
      rd(`ASF_OFS_STAT1, 8'hD0);
      rd(`ASF_OFS_DATA, 8'hA5);
      // Idle stays down until a new character arrives
      wr(`ASF_OFS_CTRL2, 8'h34);
      asf_core_model_i.ev(1'b1, 1'b0);
      rd(`ASF_OFS_STAT1, 8'hC0);
      asf_core_model_i.push(9'h011, 1'b0, 1'b0, 1'b0);
      rd(`ASF_OFS_STAT1, 8'hE0);
      rd(`ASF_OFS_DATA, 8'h11);
      asf_core_model_i.ev(1'b1, 1'b0);
      rd(`ASF_OFS_STAT1, 8'hD0);
      // Break flag masked, enabled, cleared
      wr(`ASF_OFS_CTRL2, 8'h04);
      asf_core_model_i.ev(1'b0, 1'b1);
      rd(`ASF_OFS_STAT2, 8'h80);
      chk("irq_rx", 1'b0, irq_rx);
      wr(`ASF_OFS_CTRL4, 8'h80);
      chk("irq_rx", 1'b1, irq_rx);
      wr(`ASF_OFS_STAT2, 8'h80);
      rd(`ASF_OFS_STAT2, 8'h00);
      // Receive edge, write one to clear, wake in light stop
      rxd_pin <= 1'b0;
      step(2);
      rxd_pin <= 1'b1;
      wr(`ASF_OFS_STAT2, 8'h00);
      rd(`ASF_OFS_STAT2, 8'h40);
      wr(`ASF_OFS_CTRL4, 8'h40);
      stop_light <= 1'b1;
      step(1);
      chk("wake", 1'b1, wake_request);
      stop_light <= 1'b0;
      wr(`ASF_OFS_STAT2, 8'h40);
      rd(`ASF_OFS_STAT2, 8'h00);
      wr(`ASF_OFS_CTRL2, 8'h00);
      rxd_pin <= 1'b0;
      step(2);
      rxd_pin <= 1'b1;
      rd(`ASF_OFS_STAT2, 8'h00);
      // Loop mode, then single wire both directions
      wr(`ASF_OFS_CTRL1, 8'h80);
      chk("release", 1'b1, rxd_gpio_release);
      wr(`ASF_OFS_DATA, 8'h55);
      wait_for(4);
      for (int i = 0; i < 6; i++) begin
         @(negedge aclk);
         chk("loop", tx_serial_out, rx_serial_in);
      end
      wait_for(5);
      @(posedge aclk);
      wr(`ASF_OFS_CTRL1, 8'hA0);
      wr(`ASF_OFS_CTRL3, 8'h00);
      chk("oe_n", 1'b1, txd_pin_oe_n);
      for (int i = 0; i < 2; i++) begin
         ext_txd <= i[0];
         step(1);
         chk("single", i[0], rx_serial_in);
      end
      wr(`ASF_OFS_CTRL3, 8'h20);
      chk("oe_n", 1'b0, txd_pin_oe_n);
      wr(`ASF_OFS_DATA, 8'h3C);
      wait_for(4);
      for (int i = 0; i < 6; i++) begin
         @(negedge aclk);
         chk("echo", {2{tx_serial_out}}, {txd_pin_out, rx_serial_in});
      end
      wait_for(5);
      @(posedge aclk);
      // Unmapped place, then deep stop wipes registers
      rd(8'h1C, 8'h00, ASF_RESP_SLVERR);
      wr(8'h1C, 8'hFF, ASF_RESP_SLVERR);
      wr(`ASF_OFS_CTRL2, 8'h84);
      stop_deep <= 1'b1;
      step(1);
      stop_deep <= 1'b0;
      rd(`ASF_OFS_CTRL2, 8'h00);
      finish_test;
   end
endmodule
